// ===== tmr_defines.svh
/*
 * Register offsets, field positions, reset values and fixed TOP values
 * of the 16-bit PWM timer. Assumes an 8-bit APB byte address.
 */
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_COUNT 8'h04
`define TMR_OFS_CMP_A 8'h08
`define TMR_OFS_CMP_B 8'h0C
`define TMR_OFS_CAPTOP 8'h10
`define TMR_OFS_FLAGS 8'h14
`define TMR_OFS_STATUS 8'h18
`define TMR_OFS_ACT_A 8'h1C
`define TMR_OFS_ACT_B 8'h20

// ==========================================================
// Control fields
`define TMR_CTRL_MODE 3:0
`define TMR_CTRL_COM_A 5:4
`define TMR_CTRL_COM_B 7:6
`define TMR_CTRL_PRESC 10:8
`define TMR_CTRL_SRST 11
`define TMR_CTRL_DIR_A 12
`define TMR_CTRL_DIR_B 13
`define TMR_CTRL_W 14
`define TMR_CTRL_RST 14'h0000

// ==========================================================
// Flag and status bits
`define TMR_FLG_OVF 0
`define TMR_FLG_CMP_A 1
`define TMR_FLG_CMP_B 2
`define TMR_FLG_CAP 3
`define TMR_ST_DOWN 0
`define TMR_ST_OC_A 1
`define TMR_ST_OC_B 2

// ==========================================================
// Fixed TOP values and prescaler limits
`define TMR_TOP_8BIT 16'h00FF
`define TMR_TOP_9BIT 16'h01FF
`define TMR_TOP_10BIT 16'h03FF
`define TMR_TOP_MAX 16'hFFFF
`define TMR_PRE_LIM_1 10'h000
`define TMR_PRE_LIM_8 10'h007
`define TMR_PRE_LIM_64 10'h03F
`define TMR_PRE_LIM_256 10'h0FF
`define TMR_PRE_LIM_1024 10'h3FF

`endif

// ===== tmr_pkg.sv
/*
 * Types of the 16-bit PWM timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tmr_pkg;
  typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_t;
  typedef enum logic [1:0] {TMR_IDLE, TMR_FAST, TMR_PHASE} tmr_kind_t;
  typedef enum logic [1:0] {TMR_TOP_FIXED, TMR_TOP_CAP, TMR_TOP_CMPA} tmr_topsrc_t;
endpackage : tmr_pkg

// ===== tmr_pwm.sv
/*
 * 16-bit timer with fast PWM and phase correct PWM waveform generation,
 * two compare channels, APB register access.
 * Assumes an APB master on pclk and compare pins resolved outside.
 */
// Notes on behaviour
// - Modes 5, 6, 7, 14, 15 run fast PWM, counting up then restarting.
// - Fast PWM TOP is 0xFF, 0x1FF, 0x3FF, capture or compare A.
// - Fast PWM counter clears to zero on the tick after it equals TOP.
// - Fast PWM mode two clears on match, sets at BOTTOM; three inverts.
// - Fast PWM sets overflow at TOP, plus compare A or capture flag.
// - Each channel flag sets when counter equals its active compare value.
// - Fixed TOP masks upper compare bits on any compare write.
// - Capture TOP is unbuffered; missed TOP wraps through 0xFFFF first.
// - Fast PWM compare writes buffered; active loads at TOP with clear.
// - Fast PWM compare zero gives spike; compare TOP gives constant level.
// - Fast PWM channel A mode one toggles on each match.
// - Modes 1, 2, 3, 10, 11 run phase correct PWM, up then down.
// - Phase correct TOP is 0xFF, 0x1FF, 0x3FF, capture or compare A.
// - Phase correct counter holds TOP one tick before counting down.
// - Phase correct mode two clears on up match, sets on down match.
// - Phase correct sets overflow flag each time counter reaches BOTTOM.
// - Phase correct loads compares at TOP, setting compare A or capture flag.
// - Phase correct compare BOTTOM stays low, TOP stays high, inverted flips.
// - Counter advances only on prescaled tick of 1, 8, 64, 256, 1024.
// - Output mode zero leaves compare output state unchanged.
// - System reset clears each compare output state to zero.
`include "tmr_defines.svh"

module tmr_pwm import tmr_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compare_output_a,
  output logic compare_output_a_oe_n,
  output logic compare_output_b,
  output logic compare_output_b_oe_n
);

  // ==========================================================
  // Mode decoding
  function automatic tmr_kind_t mode_kind(input logic [3:0] m);
    unique case (m)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_kind = TMR_FAST;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_kind = TMR_PHASE;
      default: mode_kind = TMR_IDLE;
    endcase
  endfunction : mode_kind

  function automatic tmr_topsrc_t top_src(input logic [3:0] m);
    unique case (m)
      4'hE, 4'hA: top_src = TMR_TOP_CAP;
      4'hF, 4'hB: top_src = TMR_TOP_CMPA;
      default: top_src = TMR_TOP_FIXED;
    endcase
  endfunction : top_src

  // Fixed TOP doubles as the compare mask
  function automatic logic [15:0] fixed_top(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h5: fixed_top = `TMR_TOP_8BIT;
      4'h2, 4'h6: fixed_top = `TMR_TOP_9BIT;
      4'h3, 4'h7: fixed_top = `TMR_TOP_10BIT;
      default: fixed_top = `TMR_TOP_MAX;
    endcase
  endfunction : fixed_top

  function automatic logic [9:0] presc_limit(input logic [2:0] s);
    unique case (s)
      3'h1: presc_limit = `TMR_PRE_LIM_1;
      3'h2: presc_limit = `TMR_PRE_LIM_8;
      3'h3: presc_limit = `TMR_PRE_LIM_64;
      3'h4: presc_limit = `TMR_PRE_LIM_256;
      default: presc_limit = `TMR_PRE_LIM_1024;
    endcase
  endfunction : presc_limit

  // ==========================================================
  // State
  logic [`TMR_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0] count_value_r, count_value_nxt;
  logic [15:0] capture_top_value_r, capture_top_value_nxt;
  logic [15:0] buf_r [2];
  logic [15:0] buf_nxt [2];
  logic [15:0] act_r [2];
  logic [15:0] act_nxt [2];
  logic [1:0] oc_r, oc_nxt;
  logic [1:0] oe_n_r, oe_n_nxt;
  logic [3:0] flags_r, flags_nxt;
  tmr_dir_t dir_r, dir_nxt;
  logic [9:0] presc_r, presc_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [3:0] mode;
    logic [1:0] com [2];
    tmr_kind_t kind;
    tmr_topsrc_t tsrc;
    logic [15:0] top;
    logic [15:0] mask;
    logic tick;
    logic at_top;
    logic up_ph;
    logic match;
    logic [3:0] fset;
    logic [3:0] fclr;
    logic acc;
    logic wr;
    logic cmp_wr;
    match = 1'b0;
    mode = ctrl_r[`TMR_CTRL_MODE];
    com[0] = ctrl_r[`TMR_CTRL_COM_A];
    com[1] = ctrl_r[`TMR_CTRL_COM_B];
    kind = mode_kind(mode);
    tsrc = top_src(mode);
    mask = fixed_top(mode);
    unique case (tsrc)
      TMR_TOP_CAP: top = capture_top_value_r;
      TMR_TOP_CMPA: top = act_r[0];
      default: top = mask;
    endcase
    at_top = count_value_r == top;
    fset = 4'h0;
    fclr = 4'h0;

    ctrl_nxt = ctrl_r;
    ctrl_nxt[`TMR_CTRL_SRST] = 1'b0;
    count_value_nxt = count_value_r;
    capture_top_value_nxt = capture_top_value_r;
    buf_nxt = buf_r;
    act_nxt = act_r;
    oc_nxt = oc_r;
    dir_nxt = dir_r;

    // Prescaled timer tick
    tick = ctrl_r[`TMR_CTRL_PRESC] != 3'h0 && presc_r == presc_limit(ctrl_r[`TMR_CTRL_PRESC]);
    if (ctrl_r[`TMR_CTRL_PRESC] == 3'h0 || tick) begin
      presc_nxt = 10'h000;
    end else begin
      presc_nxt = presc_r + 10'h001;
    end

    // Phase of a match: TOP counts as falling, BOTTOM as rising
    up_ph = (dir_r == TMR_UP && !at_top) || (dir_r == TMR_DOWN && count_value_r == 16'h0000);

    // Counter
    if (tick && kind == TMR_FAST) begin
      if (at_top) begin
        count_value_nxt = 16'h0000;
        fset[`TMR_FLG_OVF] = 1'b1;
        act_nxt = buf_r;
        if (tsrc == TMR_TOP_CAP) begin
          fset[`TMR_FLG_CAP] = 1'b1;
        end
        if (tsrc == TMR_TOP_CMPA) begin
          fset[`TMR_FLG_CMP_A] = 1'b1;
        end
      end else begin
        count_value_nxt = count_value_r + 16'h0001;
      end
    end else if (tick && kind == TMR_PHASE) begin
      if (dir_r == TMR_UP) begin
        if (at_top) begin
          dir_nxt = TMR_DOWN;
          count_value_nxt = count_value_r - 16'h0001;
          act_nxt = buf_r;
          if (tsrc == TMR_TOP_CAP) begin
            fset[`TMR_FLG_CAP] = 1'b1;
          end
          if (tsrc == TMR_TOP_CMPA) begin
            fset[`TMR_FLG_CMP_A] = 1'b1;
          end
        end else begin
          count_value_nxt = count_value_r + 16'h0001;
        end
      end else begin
        if (count_value_r == 16'h0000) begin
          dir_nxt = TMR_UP;
          count_value_nxt = 16'h0001;
          fset[`TMR_FLG_OVF] = 1'b1;
        end else begin
          count_value_nxt = count_value_r - 16'h0001;
        end
      end
    end

    // Compare channels
    for (int i = 0; i < 2; i++) begin
      match = count_value_r == act_r[i];
      if (tick && kind != TMR_IDLE && match) begin
        fset[`TMR_FLG_CMP_A + i] = 1'b1;
      end
      if (tick && kind == TMR_FAST) begin
        unique case (com[i])
          2'h2: begin
            if (at_top) begin
              oc_nxt[i] = 1'b1;
            end else if (match) begin
              oc_nxt[i] = 1'b0;
            end
          end
          2'h3: begin
            if (at_top) begin
              oc_nxt[i] = 1'b0;
            end else if (match) begin
              oc_nxt[i] = 1'b1;
            end
          end
          2'h1: begin
            if (i == 0 && match) begin
              oc_nxt[i] = ~oc_r[i];
            end
          end
          2'h0: oc_nxt[i] = oc_r[i];
        endcase
      end else if (tick && kind == TMR_PHASE && match) begin
        unique case (com[i])
          2'h2: oc_nxt[i] = ~up_ph;
          2'h3: oc_nxt[i] = up_ph;
          default: oc_nxt[i] = oc_r[i];
        endcase
      end
      oe_n_nxt[i] = !(ctrl_r[`TMR_CTRL_DIR_A + i] && com[i] != 2'h0);
    end

    // APB slave: one wait state, write at the completing edge
    acc = psel && penable && !pready_r;
    wr = psel && penable && pready_r && pwrite;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (acc) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `TMR_OFS_CTRL: prdata_nxt = {18'h0, ctrl_r};
        `TMR_OFS_COUNT: prdata_nxt = {16'h0, count_value_r};
        `TMR_OFS_CMP_A: prdata_nxt = {16'h0, buf_r[0]};
        `TMR_OFS_CMP_B: prdata_nxt = {16'h0, buf_r[1]};
        `TMR_OFS_CAPTOP: prdata_nxt = {16'h0, capture_top_value_r};
        `TMR_OFS_FLAGS: prdata_nxt = {28'h0, flags_r};
        `TMR_OFS_STATUS: prdata_nxt = {29'h0, oc_r, dir_r == TMR_DOWN};
        `TMR_OFS_ACT_A: prdata_nxt = {16'h0, act_r[0]};
        `TMR_OFS_ACT_B: prdata_nxt = {16'h0, act_r[1]};
        default: pslverr_nxt = 1'b1;
      endcase
    end

    cmp_wr = 1'b0;
    if (wr) begin
      unique case (paddr)
        `TMR_OFS_CTRL: ctrl_nxt = pwdata[`TMR_CTRL_W-1:0];
        `TMR_OFS_COUNT: count_value_nxt = pwdata[15:0];
        `TMR_OFS_CMP_A: begin
          buf_nxt[0] = pwdata[15:0];
          cmp_wr = 1'b1;
        end
        `TMR_OFS_CMP_B: begin
          buf_nxt[1] = pwdata[15:0];
          cmp_wr = 1'b1;
        end
        `TMR_OFS_CAPTOP: capture_top_value_nxt = pwdata[15:0];
        `TMR_OFS_FLAGS: fclr = pwdata[3:0];
        default: cmp_wr = 1'b0;
      endcase
    end
    if (cmp_wr) begin
      for (int i = 0; i < 2; i++) begin
        buf_nxt[i] = buf_nxt[i] & mask;
        if (kind == TMR_IDLE) begin
          act_nxt[i] = buf_nxt[i];
        end
      end
    end

    // Set wins over a clear in the same cycle
    flags_nxt = (flags_r & ~fclr) | fset;

    // Soft reset
    if (ctrl_r[`TMR_CTRL_SRST]) begin
      count_value_nxt = 16'h0000;
      capture_top_value_nxt = 16'h0000;
      buf_nxt[0] = 16'h0000;
      buf_nxt[1] = 16'h0000;
      act_nxt[0] = 16'h0000;
      act_nxt[1] = 16'h0000;
      flags_nxt = 4'h0;
      dir_nxt = TMR_UP;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TMR_CTRL_RST;
      count_value_r <= 16'h0000;
      capture_top_value_r <= 16'h0000;
      buf_r[0] <= 16'h0000;
      buf_r[1] <= 16'h0000;
      act_r[0] <= 16'h0000;
      act_r[1] <= 16'h0000;
      oc_r <= 2'h0;
      oe_n_r <= 2'h3;
      flags_r <= 4'h0;
      dir_r <= TMR_UP;
      presc_r <= 10'h000;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_value_r <= count_value_nxt;
      capture_top_value_r <= capture_top_value_nxt;
      buf_r <= buf_nxt;
      act_r <= act_nxt;
      oc_r <= oc_nxt;
      oe_n_r <= oe_n_nxt;
      flags_r <= flags_nxt;
      dir_r <= dir_nxt;
      presc_r <= presc_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign compare_output_a = oc_r[0];
  assign compare_output_b = oc_r[1];
  assign compare_output_a_oe_n = oe_n_r[0];
  assign compare_output_b_oe_n = oe_n_r[1];

endmodule : tmr_pwm

// ===== tmr_pwm_properties.sv
/* Port checker for tmr_pwm: APB handshake, pin enables, output holds.
   Assumes the bench APB master; bound to every tmr_pwm instance. */
`include "tmr_defines.svh"
module tmr_pwm_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare_output_a,
  input wire logic compare_output_a_oe_n,
  input wire logic compare_output_b,
  input wire logic compare_output_b_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Shadow of the control register
  logic [13:0] ctrl_r;
  logic [13:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (psel && penable && pready && pwrite && paddr == `TMR_OFS_CTRL) begin
      ctrl_nxt = pwdata[13:0] & 14'h37FF;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 14'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // ==========================================
  // Assertions
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_reset_out_low: assert property ($rose(presetn) |-> !compare_output_a && !compare_output_b)
    else $error("output state not cleared by reset");
  a_oe_a_ctrl: assert property (ctrl_r == $past(ctrl_r) |->
    compare_output_a_oe_n == !(ctrl_r[12] && ctrl_r[5:4] != 2'b00)) else $error("oe a wrong");
  a_oe_b_ctrl: assert property (ctrl_r == $past(ctrl_r) |->
    compare_output_b_oe_n == !(ctrl_r[13] && ctrl_r[7:6] != 2'b00)) else $error("oe b wrong");
  a_hold_mode_a: assert property (ctrl_r[5:4] == 2'b00 |=> $stable(compare_output_a))
    else $error("output a moved in mode zero");
  a_hold_mode_b: assert property (ctrl_r[7:6] == 2'b00 |=> $stable(compare_output_b))
    else $error("output b moved in mode zero");
  a_hold_stopped: assert property (ctrl_r[10:8] == 3'b000 |=>
    $stable(compare_output_a) && $stable(compare_output_b)) else $error("output moved when stopped");
  c_ctrl_write: cover property (psel && penable && pready && pwrite && paddr == `TMR_OFS_CTRL);
  c_slave_err: cover property (pslverr);
  c_out_a_rise: cover property ($rose(compare_output_a));
endmodule : tmr_pwm_properties

bind tmr_pwm tmr_pwm_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_output_a(compare_output_a),
  .compare_output_a_oe_n(compare_output_a_oe_n), .compare_output_b(compare_output_b),
  .compare_output_b_oe_n(compare_output_b_oe_n));

// ===== tb_tmr_pwm.sv
/* Self-checking bench for tmr_pwm: registers, fast and phase correct PWM.
   Assumes the design files and the checker are compiled before it. */
`include "tmr_defines.svh"
module tb_tmr_pwm;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic out_a, oe_a, out_b, oe_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  tmr_pwm u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_output_a(out_a), .compare_output_a_oe_n(oe_a),
    .compare_output_b(out_b), .compare_output_b_oe_n(oe_b));
  // ==========================================
  // Shared tasks
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task poll(input logic [31:0] m);
    do begin
      apb(1'b0, `TMR_OFS_FLAGS, 32'h0);
    end while ((q & m) == 32'h0);
  endtask : poll
  // Clock edges until the chosen output changes
  task edge_gap(input logic b, output int n);
    logic v;
    v = b ? out_b : out_a;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((b ? out_b : out_a) === v);
  endtask : edge_gap
  // ==========================================
  // Scenarios
  task t_regs;
    rdc(`TMR_OFS_STATUS, 32'h0);
    chk(oe_a, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, `TMR_OFS_CTRL, 32'h5);
    apb(1'b1, `TMR_OFS_CMP_A, 32'h1234);
    rdc(`TMR_OFS_CMP_A, 32'h34);
    $display("t_regs done");
  endtask : t_regs
  task t_fast;
    apb(1'b1, `TMR_OFS_CTRL, 32'h30EE);
    apb(1'b1, `TMR_OFS_CMP_A, 32'h3);
    apb(1'b1, `TMR_OFS_CMP_B, 32'h5);
    apb(1'b1, `TMR_OFS_CAPTOP, 32'h7);
    apb(1'b1, `TMR_OFS_COUNT, 32'h6);
    rdc(`TMR_OFS_ACT_A, 32'h0);
    apb(1'b1, `TMR_OFS_FLAGS, 32'hF);
    apb(1'b1, `TMR_OFS_CTRL, 32'h35EE);
    poll(32'h1);
    chk(q, 32'h9);
    rdc(`TMR_OFS_COUNT, 32'h0);
    rdc(`TMR_OFS_ACT_A, 32'h3);
    chk(out_a, 1'b1);
    chk(out_b, 1'b0);
    chk(oe_a, 1'b0);
    chk(oe_b, 1'b0);
    apb(1'b1, `TMR_OFS_FLAGS, 32'hF);
    poll(32'h2);
    chk(q, 32'h2);
    chk(out_a, 1'b0);
    poll(32'h4);
    chk(out_b, 1'b1);
    $display("t_fast done");
  endtask : t_fast
  task t_phase;
    apb(1'b1, `TMR_OFS_CTRL, 32'h38EA);
    rdc(`TMR_OFS_COUNT, 32'h0);
    rdc(`TMR_OFS_ACT_A, 32'h0);
    rdc(`TMR_OFS_CAPTOP, 32'h0);
    rdc(`TMR_OFS_FLAGS, 32'h0);
    rdc(`TMR_OFS_CTRL, 32'h30EA);
    apb(1'b1, `TMR_OFS_CMP_A, 32'h2);
    apb(1'b1, `TMR_OFS_CAPTOP, 32'h4);
    apb(1'b1, `TMR_OFS_COUNT, 32'h3);
    apb(1'b1, `TMR_OFS_CTRL, 32'h35EA);
    poll(32'h8);
    chk(q, 32'h8);
    rdc(`TMR_OFS_ACT_A, 32'h2);
    rdc(`TMR_OFS_COUNT, 32'h3);
    apb(1'b0, `TMR_OFS_STATUS, 32'h0);
    chk(q[0], 1'b1);
    poll(32'h2);
    chk(out_a, 1'b1);
    poll(32'h1);
    chk(out_b, 1'b1);
    rdc(`TMR_OFS_COUNT, 32'h1);
    $display("t_phase done");
  endtask : t_phase
  task t_wave;
    int n;
    apb(1'b1, `TMR_OFS_CTRL, 32'h081F);
    apb(1'b1, `TMR_OFS_CMP_A, 32'h3);
    apb(1'b1, `TMR_OFS_CTRL, 32'h111F);
    edge_gap(1'b0, n);
    edge_gap(1'b0, n);
    chk(n, 32'h4);
    edge_gap(1'b0, n);
    chk(n, 32'h4);
    chk(out_b, 1'b1);
    chk(oe_b, 1'b1);
    rdc(`TMR_OFS_FLAGS, 32'h7);
    apb(1'b1, `TMR_OFS_CTRL, 32'h119F);
    edge_gap(1'b1, n);
    edge_gap(1'b1, n);
    chk(n, 32'h3);
    edge_gap(1'b1, n);
    chk(n, 32'h1);
    $display("t_wave done");
  endtask : t_wave
  // ==========================================
  // Watchdog and main sequence
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 40000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fast();
    t_phase();
    t_wave();
    results();
  end
endmodule : tb_tmr_pwm
